// *** rtl/djh_defs.svh ***
`ifndef DJH_DEFS_SVH
`define DJH_DEFS_SVH

// ****************************************
// timing
// ****************************************
`define DJH_CLK_KHZ 100000
`define DJH_MS 1
`define DJH_MS_CYC (`DJH_MS * `DJH_CLK_KHZ)
`define DJH_PREP_MS 100
`define DJH_PREP_CYC (`DJH_PREP_MS * `DJH_CLK_KHZ)
`define DJH_HOLD_MS 500

// ****************************************
// register offsets
// ****************************************
`define DJH_OFS_CTRL 8'h00
`define DJH_OFS_STAT 8'h04
`define DJH_OFS_TMR 8'h08
`define DJH_OFS_SSEL 8'h0c
`define DJH_OFS_SDAT 8'h10
`define DJH_OFS_AMNT 8'h14

// ****************************************
// fields and reset values
// ****************************************
`define DJH_CTRL_RUN 0
`define DJH_CTRL_TRIG 1
`define DJH_CTRL_TMR 2
`define DJH_STAT_READY 0
`define DJH_STAT_ACTIVE 1
`define DJH_STAT_ADV 2
`define DJH_STAT_STYLE_LO 8
`define DJH_STAT_STYLE_HI 15
`define DJH_TMR_RST 16'h0064
`define DJH_DEF_STYLE 8'h01
`define DJH_PURGE_STYLE 8'h00
`define DJH_TGT_LO 0
`define DJH_TGT_HI 15
`define DJH_TOL_LO 16
`define DJH_TOL_HI 31

`endif

// *** rtl/djh_pkg.sv ***
package djh_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PREP,
    ST_RUN,
    ST_EVAL,
    ST_FIN,
    ST_WAIT
  } djh_state_e;
  typedef logic [7:0] djh_style_t;
  typedef logic [15:0] djh_amount_t;
endpackage

// *** rtl/djh_tick.sv ***
`timescale 1ns/100ps
module djh_tick #(
  parameter int DIV = 100000
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // one-cycle enable every DIV cycles
  output logic tick_o
);
  localparam int CW = $clog2(DIV + 1);
  logic [CW-1:0] cnt_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
      tick_o <= 1'b0;
    end else if (cnt_r == CW'(DIV - 1)) begin
      cnt_r <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_r <= cnt_r + CW'(1);
      tick_o <= 1'b0;
    end
  end
endmodule

// *** rtl/djh_style_mem.sv ***
`timescale 1ns/100ps
module djh_style_mem #(
  parameter int AW = 8,
  parameter int DW = 32
) (
  // clock
  input wire logic clk_i,
  // write port
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  // registered read port
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem_r [0:(1<<AW)-1];

  // no reset: contents are software-loaded before use
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_r[raddr_i];
  end
endmodule

// *** rtl/djh_top.sv ***
// Notes on behaviour
// - jobs start only while the run (active) control bit is set
// - strobe rise samples style, starts job, raises job-active
// - after job-done, result outputs are updated from evaluation
// - job-active falls only after results are valid
// - one plate per job; this plate keeps its own style table
// - trigger-only start uses style one, no strobe
// - trigger-only start always waits a fixed 100 ms preparing
// - trigger-only jobs end by timer only, never job-done
// - prefill selects exist only on the fieldbus variant
// - job-end timer restarts while any valve is open, expires past preset
// - style latched at start, ignored until next job
// - style zero is purge only, never evaluated as production
`timescale 1ns/100ps
`include "djh_defs.svh"
module djh_top import djh_pkg::*; #(
  parameter int NV = 4,
  parameter bit FIELDBUS = 1'b1,
  parameter int MS_CYC = `DJH_MS_CYC,
  parameter int PREP_CYC = `DJH_PREP_CYC,
  parameter int HOLD_MS = `DJH_HOLD_MS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // controller handshake inputs
  input wire logic [7:0] style_i,
  input wire logic style_strobe_i,
  input wire logic job_done_i,
  input wire logic [NV-1:0] valve_on_i,
  input wire logic [NV-1:0] prefill_sel_i,
  input wire logic trigger_i,
  input wire logic meter_pulse_i,
  // handshake outputs
  output logic ready_o,
  output logic job_active_o,
  output logic no_alarm_o,
  output logic no_fault_o,
  output logic vol_ok_o,
  output logic error_o,
  output logic [15:0] amount_o,
  output logic advisory_o,
  output logic [NV-1:0] valve_open_o,
  output logic [NV-1:0] prefill_o
);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  function automatic logic [31:0] lanes(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************
  // input synchroniser
  // ****************************************
  localparam int I_MET = 2 * NV;
  localparam int I_TRG = I_MET + 1;
  localparam int I_DN = I_MET + 2;
  localparam int I_ST = I_MET + 3;
  localparam int I_STY = I_MET + 4;
  localparam int SW = I_STY + 8;

  logic [SW-1:0] s1_r, s2_r, s3_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= {style_i, style_strobe_i, job_done_i, trigger_i,
               meter_pulse_i, prefill_sel_i, valve_on_i};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  logic st_lvl, dn_lvl, tg_lvl;
  logic st_rise, dn_rise, tg_rise, met_rise;
  djh_style_t s_style;
  logic [NV-1:0] s_valve, s_pre, v_eff;
  assign st_lvl = s2_r[I_ST];
  assign dn_lvl = s2_r[I_DN];
  assign tg_lvl = s2_r[I_TRG];
  assign st_rise = rise(s2_r[I_ST], s3_r[I_ST]);
  assign dn_rise = rise(s2_r[I_DN], s3_r[I_DN]);
  assign tg_rise = rise(s2_r[I_TRG], s3_r[I_TRG]);
  assign met_rise = rise(s2_r[I_MET], s3_r[I_MET]);
  assign s_style = s2_r[I_STY +: 8];
  assign s_valve = s2_r[NV-1:0];
  assign s_pre = s2_r[NV +: NV];

  // ****************************************
  // registers
  // ****************************************
  logic run_r, trig_r, tmr_end_r, adv_r;
  logic [15:0] preset_r;
  djh_style_t ssel_r;
  djh_state_e state_r;
  djh_style_t style_r;
  djh_amount_t amt_r;
  logic ack_r;
  logic req, wr;
  logic mem_we;
  logic [31:0] mem_rd, ctrl_w;
  logic ms_tick;

  assign req = wb_cyc_i & wb_stb_i & ~ack_r;
  // writes land on the ack edge, while the request still stands
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
  assign ctrl_w = lanes({29'h0, tmr_end_r, trig_r, run_r}, wb_dat_i,
                        wb_sel_i);
  assign mem_we = wr && wb_adr_i == `DJH_OFS_SDAT && wb_sel_i == 4'hf;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_r <= 1'b0;
      trig_r <= 1'b0;
      tmr_end_r <= 1'b0;
      preset_r <= `DJH_TMR_RST;
      ssel_r <= '0;
    end else if (wr) begin
      unique case (wb_adr_i)
        `DJH_OFS_CTRL: begin
          run_r <= ctrl_w[`DJH_CTRL_RUN];
          trig_r <= ctrl_w[`DJH_CTRL_TRIG];
          tmr_end_r <= ctrl_w[`DJH_CTRL_TMR];
        end
        `DJH_OFS_TMR: preset_r <= 16'(lanes({16'h0, preset_r}, wb_dat_i,
                                            wb_sel_i));
        `DJH_OFS_SSEL: ssel_r <= 8'(lanes({24'h0, ssel_r}, wb_dat_i,
                                          wb_sel_i));
        default: begin
        end
      endcase
    end
  end

  // single-cycle ack; unmapped reads return zero, writes are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      ack_r <= req;
      wb_dat_o <= '0;
      if (req && !wb_we_i) begin
        unique case (wb_adr_i)
          `DJH_OFS_CTRL: wb_dat_o <= {29'h0, tmr_end_r, trig_r, run_r};
          `DJH_OFS_STAT: begin
            wb_dat_o[`DJH_STAT_READY] <= ready_o;
            wb_dat_o[`DJH_STAT_ACTIVE] <= job_active_o;
            wb_dat_o[`DJH_STAT_ADV] <= adv_r;
            wb_dat_o[`DJH_STAT_STYLE_HI:`DJH_STAT_STYLE_LO] <= style_r;
          end
          `DJH_OFS_TMR: wb_dat_o <= {16'h0, preset_r};
          `DJH_OFS_SSEL: wb_dat_o <= {24'h0, ssel_r};
          `DJH_OFS_AMNT: wb_dat_o <= {16'h0, amount_o};
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end
  assign wb_ack_o = ack_r;

  // ****************************************
  // style table and millisecond tick
  // ****************************************
  // one table per plate instance, so plates never share styles
  djh_style_mem #(.AW(8), .DW(32)) u_mem (
    .clk_i(clk_i),
    .we_i(mem_we),
    .waddr_i(ssel_r),
    .wdata_i(wb_dat_i),
    .raddr_i(style_r),
    .rdata_o(mem_rd)
  );

  djh_tick #(.DIV(MS_CYC)) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(ms_tick)
  );

  // ****************************************
  // job sequencer
  // ****************************************
  logic [23:0] prep_cnt_r;
  logic [15:0] tmr_r;
  logic tmo, end_cond, in_tol, gw_start, tg_start;
  logic [15:0] diff;

  assign gw_start = run_r && !trig_r && st_rise && !dn_lvl;
  assign tg_start = run_r && trig_r && tg_rise;
  assign v_eff = trig_r ? NV'(tg_lvl) : s_valve;
  assign tmo = tmr_r > preset_r;
  // trigger-only jobs ignore job-done for ending; ST_WAIT still waits for it low
  assign end_cond = (trig_r || tmr_end_r) ? tmo : dn_rise;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (gw_start) begin
            state_r <= ST_RUN;
          end else if (tg_start) begin
            state_r <= ST_PREP;
          end
        end
        ST_PREP: begin
          if (prep_cnt_r == 24'(PREP_CYC - 1)) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (end_cond) begin
            state_r <= ST_EVAL;
          end
        end
        ST_EVAL: state_r <= ST_FIN;
        ST_FIN: state_r <= ST_WAIT;
        ST_WAIT: begin
          if (!st_lvl && !dn_lvl) begin
            state_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prep_cnt_r <= '0;
    end else if (state_r == ST_PREP) begin
      prep_cnt_r <= prep_cnt_r + 24'h000001;
    end else begin
      prep_cnt_r <= '0;
    end
  end

  // latched once per job, later style changes are ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      style_r <= `DJH_DEF_STYLE;
    end else if (state_r == ST_IDLE && gw_start) begin
      style_r <= s_style;
    end else if (state_r == ST_IDLE && tg_start) begin
      style_r <= `DJH_DEF_STYLE;
    end
  end

  // idle timer restarts whenever any valve is open
  always_ff @(posedge clk_i) begin
    if (rst_i || state_r != ST_RUN || |v_eff) begin
      tmr_r <= '0;
    end else if (ms_tick && tmr_r != 16'hffff) begin
      tmr_r <= tmr_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || (state_r == ST_IDLE && (gw_start || tg_start))) begin
      amt_r <= '0;
    end else if ((state_r == ST_PREP || state_r == ST_RUN) && met_rise &&
                 amt_r != 16'hffff) begin
      amt_r <= amt_r + 16'h0001;
    end
  end

  // ****************************************
  // results and handshake outputs
  // ****************************************
  assign diff = (amt_r > mem_rd[`DJH_TGT_HI:`DJH_TGT_LO])
              ? amt_r - mem_rd[`DJH_TGT_HI:`DJH_TGT_LO]
              : mem_rd[`DJH_TGT_HI:`DJH_TGT_LO] - amt_r;
  // purge style skips the volume check
  assign in_tol = (style_r == `DJH_PURGE_STYLE) ||
                  (diff <= mem_rd[`DJH_TOL_HI:`DJH_TOL_LO]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      no_alarm_o <= 1'b1;
      no_fault_o <= 1'b1;
      vol_ok_o <= 1'b0;
      error_o <= 1'b0;
      amount_o <= '0;
    end else if (state_r == ST_EVAL) begin
      no_alarm_o <= in_tol;
      no_fault_o <= !adv_r;
      vol_ok_o <= in_tol;
      error_o <= !in_tol;
      amount_o <= amt_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      job_active_o <= 1'b0;
    end else if (state_r == ST_IDLE && (gw_start || tg_start)) begin
      job_active_o <= 1'b1;
    end else if (state_r == ST_FIN) begin
      job_active_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= run_r && state_r == ST_IDLE && !st_lvl && !dn_lvl;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valve_open_o <= '0;
      prefill_o <= '0;
    end else begin
      valve_open_o <= (state_r == ST_RUN) ? v_eff : '0;
      // discrete variant has no prefill method at all
      prefill_o <= (FIELDBUS && job_active_o) ? s_pre : '0;
    end
  end

  // held job-done: count ms while high; set wins over clear
  logic [15:0] hold_r;
  logic adv_clr;
  assign adv_clr = wr && wb_adr_i == `DJH_OFS_STAT && wb_sel_i[0] &&
                   wb_dat_i[`DJH_STAT_ADV];
  always_ff @(posedge clk_i) begin
    if (rst_i || !dn_lvl) begin
      hold_r <= '0;
    end else if (ms_tick && hold_r != 16'hffff) begin
      hold_r <= hold_r + 16'h0001;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adv_r <= 1'b0;
    end else if (dn_lvl && hold_r == 16'(HOLD_MS)) begin
      adv_r <= 1'b1;
    end else if (adv_clr) begin
      adv_r <= 1'b0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      advisory_o <= 1'b0;
    end else begin
      advisory_o <= adv_r;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_no_run_start: assert property (
      $rose(job_active_o) |-> $past(run_r))
    else $error("job started while not running");
  chk_strobe_start: assert property (
      state_r == ST_IDLE && gw_start |=>
      job_active_o && style_r == $past(s_style) && state_r == ST_RUN)
    else $error("strobe did not start a job");
  chk_style_hold: assert property (
      job_active_o && $past(job_active_o) |-> $stable(style_r))
    else $error("style changed during job");
  chk_done_ends: assert property (state_r == ST_RUN && !trig_r &&
      !tmr_end_r && dn_rise |=>
      state_r == ST_EVAL ##1 vol_ok_o == $past(in_tol))
    else $error("job-done did not produce results");
  chk_result_first: assert property ($fell(job_active_o) |->
      $past(state_r, 2) == ST_EVAL)
    else $error("job-active fell before results");
  chk_trig_style: assert property (state_r == ST_IDLE && tg_start |=>
      style_r == `DJH_DEF_STYLE && state_r == ST_PREP)
    else $error("trigger start not on default style");
  chk_trig_nodone: assert property (
      state_r == ST_RUN && trig_r && !tmo |=> state_r != ST_EVAL)
    else $error("trigger job ended without timer");
  chk_timer_restart: assert property (state_r == ST_RUN && |v_eff |=>
      tmr_r == 16'h0000)
    else $error("job-end timer not restarted");
  chk_prep_bound: assert property (state_r == ST_PREP |->
      prep_cnt_r < 24'(PREP_CYC))
    else $error("prepare delay overran");
  chk_prefill_gate: assert property (
      !FIELDBUS || !$past(job_active_o) |-> prefill_o == '0)
    else $error("prefill driven outside a fieldbus job");
  chk_purge_ok: assert property (state_r == ST_EVAL &&
      style_r == `DJH_PURGE_STYLE |=> !error_o && vol_ok_o)
    else $error("purge job evaluated as production");
  chk_adv_set: assert property (dn_lvl && hold_r == 16'(HOLD_MS) |=>
      adv_r ##1 advisory_o)
    else $error("held job-done gave no advisory");
endmodule

// *** verification/djh_ctl_model.sv ***
`timescale 1ns/100ps
module djh_ctl_model (
  // clock and plate status
  input wire logic clk_i,
  input wire logic ready_i,
  // controller outputs
  output logic [7:0] style_o,
  output logic style_strobe_o,
  output logic job_done_o,
  output logic [3:0] valve_on_o,
  output logic meter_pulse_o,
  output logic trigger_o
);
  // ****************************************
  // idle levels
  // ****************************************
  initial begin
    style_o = 8'h00;
    style_strobe_o = 1'b0;
    job_done_o = 1'b0;
    valve_on_o = 4'h0;
    meter_pulse_o = 1'b0;
    trigger_o = 1'b0;
  end
  // ****************************************
  // handshake steps
  // ****************************************
  // scaled stand-in for the advised spacing, keeps the run short
  task automatic gap();
    repeat (3) @(posedge clk_i);
  endtask
  task automatic start(input logic [7:0] s, input logic wr);
    int n;
    n = 0;
    while (wr && ready_i !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    style_o <= s;
    gap();
    style_strobe_o <= 1'b1;
    gap();
  endtask
  task automatic set_style(input logic [7:0] s);
    style_o <= s;
    gap();
  endtask
  task automatic valves(input logic [3:0] v);
    valve_on_o <= v;
    gap();
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      meter_pulse_o <= 1'b1;
      repeat (2) @(posedge clk_i);
      meter_pulse_o <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
  endtask
  task automatic finish();
    job_done_o <= 1'b1;
  endtask
  task automatic drop_all();
    gap();
    job_done_o <= 1'b0;
    gap();
    style_strobe_o <= 1'b0;
    gap();
  endtask
  task automatic trigger(input logic v);
    trigger_o <= v;
    gap();
  endtask
endmodule

// *** verification/test_dispense_job_handshake.sv ***
`timescale 1ns/100ps
`include "djh_defs.svh"
module test_dispense_job_handshake;
  logic clk_i, rst_i, cyc, stb, we, ack;
  logic [7:0] adr, style;
  logic [31:0] wdat, rdat, rd;
  logic [3:0] sel, valves, prefill_sel, vopen, pfo;
  logic strobe, done, meter, trig, ready, active;
  logic no_alarm, no_fault, vol_ok, err, adv;
  logic [15:0] amount;
  int failures, compares, cycles;

  djh_top #(.MS_CYC(10), .PREP_CYC(20)) dut (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .style_i(style), .style_strobe_i(strobe), .job_done_i(done),
    .valve_on_i(valves), .prefill_sel_i(prefill_sel), .trigger_i(trig),
    .meter_pulse_i(meter), .ready_o(ready), .job_active_o(active),
    .no_alarm_o(no_alarm), .no_fault_o(no_fault), .vol_ok_o(vol_ok),
    .error_o(err), .amount_o(amount), .advisory_o(adv),
    .valve_open_o(vopen), .prefill_o(pfo));
  djh_ctl_model ctl (.clk_i(clk_i), .ready_i(ready), .style_o(style),
    .style_strobe_o(strobe), .job_done_o(done), .valve_on_o(valves),
    .meter_pulse_o(meter), .trigger_o(trig));

  // ****************************************
  // clock, timeout, helpers
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end
  task automatic conclude();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // master waits for ack however long it takes; only the timeout ends it
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wait_act(input logic v, output int n);
    n = 0;
    while (active !== v && n < 600) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 600) failures++;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    chk(ready, 1'b0);
    chk(active, 1'b0);
    chk({no_alarm, no_fault, vol_ok, err, adv}, 5'h18);
    chk(amount, 16'h0000);
    wb(1'b0, `DJH_OFS_TMR, 32'h0, rd);
    chk(rd, 32'h64);
    wb(1'b0, `DJH_OFS_CTRL, 32'h0, rd);
    chk(rd, 32'h0);
    wb(1'b0, 8'h20, 32'h0, rd);
    chk(rd, 32'h0);
  endtask
  task automatic t_no_run();
    ctl.start(8'h02, 1'b0);
    repeat (20) @(posedge clk_i);
    chk(active, 1'b0);
    chk(ready, 1'b0);
    ctl.drop_all();
  endtask
  task automatic do_job(input logic [7:0] s, input int n, input logic ok,
                        input logic [15:0] amt);
    int w;
    prefill_sel <= ~prefill_sel;
    ctl.start(s, 1'b1);
    wait_act(1'b1, w);
    chk(active, 1'b1);
    chk(ready, 1'b0);
    wb(1'b0, `DJH_OFS_STAT, 32'h0, rd);
    chk(rd[15:8], s);
    ctl.set_style(8'h07);
    ctl.valves(4'h5);
    @(posedge clk_i);
    chk(vopen, 4'h5);
    chk(pfo, prefill_sel);
    ctl.valves(4'ha);
    @(posedge clk_i);
    chk(vopen, 4'ha);
    ctl.pulses(n);
    ctl.valves(4'h0);
    ctl.finish();
    wait_act(1'b0, w);
    chk({vol_ok, err}, {ok, ~ok});
    chk(no_alarm, ok);
    chk(no_fault, 1'b1);
    chk(amount, amt);
    @(posedge clk_i);
    chk(pfo, 4'h0);
    wb(1'b0, `DJH_OFS_AMNT, 32'h0, rd);
    chk(rd[15:0], amt);
    wb(1'b0, `DJH_OFS_STAT, 32'h0, rd);
    chk(rd[15:8], s);
    ctl.drop_all();
  endtask
  task automatic t_jobs();
    wb(1'b1, `DJH_OFS_CTRL, 32'h1, rd);
    wb(1'b1, `DJH_OFS_SSEL, 32'h2, rd);
    wb(1'b1, `DJH_OFS_SDAT, {16'h0001, 16'h000a}, rd);
    // partial lanes: ctrl bits untouched, table write dropped
    sel <= 4'h2;
    wb(1'b1, `DJH_OFS_CTRL, 32'h0, rd);
    sel <= 4'h7;
    wb(1'b1, `DJH_OFS_SDAT, 32'h0, rd);
    sel <= 4'hf;
    wb(1'b0, `DJH_OFS_CTRL, 32'h0, rd);
    chk(rd, 32'h1);
    do_job(8'h02, 10, 1'b1, 16'h000a);
    do_job(8'h02, 5, 1'b0, 16'h0005);
    do_job(8'h00, 3, 1'b1, 16'h0003);
  endtask
  task automatic t_held_done();
    int w;
    ctl.start(8'h02, 1'b1);
    wait_act(1'b1, w);
    ctl.finish();
    repeat (5030) @(posedge clk_i);
    chk(adv, 1'b1);
    ctl.drop_all();
    wb(1'b1, `DJH_OFS_STAT, 32'h4, rd);
    repeat (3) @(posedge clk_i);
    chk(adv, 1'b0);
  endtask
  task automatic t_timer_end();
    int w;
    wb(1'b1, `DJH_OFS_CTRL, 32'h5, rd);
    wb(1'b1, `DJH_OFS_TMR, 32'h2, rd);
    ctl.start(8'h02, 1'b1);
    wait_act(1'b1, w);
    ctl.valves(4'h3);
    ctl.valves(4'h0);
    wait_act(1'b0, w);
    chk(w > 17 && w < 40, 1'b1);
    ctl.drop_all();
  endtask
  task automatic t_trigger();
    int w;
    wb(1'b1, `DJH_OFS_CTRL, 32'h7, rd);
    wb(1'b1, `DJH_OFS_TMR, 32'h2, rd);
    ctl.trigger(1'b1);
    wait_act(1'b1, w);
    chk(vopen[0], 1'b0);
    wb(1'b0, `DJH_OFS_STAT, 32'h0, rd);
    chk(rd[15:8], `DJH_DEF_STYLE);
    repeat (30) @(posedge clk_i);
    chk(vopen[0], 1'b1);
    ctl.finish();
    repeat (20) @(posedge clk_i);
    chk(active, 1'b1);
    ctl.drop_all();
    ctl.trigger(1'b0);
    wait_act(1'b0, w);
    chk(w > 17 && w < 40, 1'b1);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    sel = 4'hf;
    prefill_sel = 4'h9;
    failures = 0;
    compares = 0;
    cycles = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_no_run();
    t_jobs();
    t_held_done();
    t_timer_end();
    t_trigger();
    conclude();
  end
endmodule
